// File: design/adcrd_top.sv
// Serial result readout, conversion sequencing and power states of the converter
`timescale 1ns/1ns
`include "adcrd_cfg.svh"
// How it works
// - Chip-select framing shows the result MSB as soon as chip_select_n falls.
// - Frame-sync framing shows the result MSB from the rising edge of frame_sync.
// - Second bit appears on the first clock rise after the first clock fall.
// - Later bits follow, descending, one per serial clock rising edge.
// - Chip select high then low mid-frame restarts the frame at the MSB.
// - A new frame_sync rise mid-frame restarts the frame at the MSB.
// - Frame_sync high at busy fall shows the new result MSB at once.
// - Format select high gives two's complement, low gives straight binary.
// - Codes are 18 bits; two's complement is straight binary with MSB inverted.
// - The result register takes the new value as busy falls.
// - Internal clock sequences conversion; the serial clock only shifts data.
// - A conversion lasts at most 1.16 us.
// - Power-down pin high powers down and floats the output; low resumes.
// - Conversion ending with qualified start low enters nap; sample start leaves.
// - Qualified start follows convert_start_n only while chip select is low.
// - Qualified start fall starts conversion; high with select low starts sampling.
// - Qualified start fall mid-conversion aborts, waits, and loads the abort code.

////////////////////////////////////////////////////////////////////////////////
module adcrd_top #(
   parameter int CONV_CYC = `ADCRD_CONV_CYC,
   parameter int NAP_CYC  = `ADCRD_NAP_CYC,
   parameter int PD_CYC   = `ADCRD_PD_CYC
) (
   // System clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    arst_n,
   // Serial link
   input  wire logic                    serial_clk,
   input  wire logic                    chip_select_n,
   input  wire logic                    frame_sync,
   output logic                         serial_out_line,
   output logic                         serial_out_oe,
   // Control pins
   input  wire logic                    convert_start_n,
   input  wire logic                    output_format_select,
   input  wire logic                    power_down_pin,
   // Analog core
   input  wire logic [`ADCRD_RES_W-1:0] core_code,
   output logic                         sample_active,
   output logic                         busy,
   output logic                         nap_active,
   output logic                         powered_down
);

   localparam int W  = `ADCRD_RES_W;
   localparam int CW = `ADCRD_CNT_W;
   localparam int SW = `ADCRD_SYNC_W;

   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYC - 1);
   localparam logic [CW-1:0] NAP_LAST  = CW'(NAP_CYC);
   localparam logic [CW-1:0] PD_LAST   = CW'(PD_CYC);

   // Straight binary to two's complement is an MSB flip
   function automatic logic [W-1:0] fmt_code(
      input logic [W-1:0] code,
      input logic         twos
   );
      fmt_code = {code[W-1] ^ twos, code[W-2:0]};
   endfunction : fmt_code

   /////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage feeds only the second

   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;
   logic [SW-1:0] sync_d;
   logic          cs_s;
   logic          cnv_s;
   logic          fmt_s;
   logic          pd_s;
   logic          fs_s;

   always_comb begin
      sync_d = {frame_sync, power_down_pin, output_format_select,
                convert_start_n, chip_select_n};
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         // Idle levels at reset, so release shows no false select, start or sync
         sync1_q <= `ADCRD_SYNC_IDLE;
         sync2_q <= `ADCRD_SYNC_IDLE;
      end else begin
         sync1_q <= sync_d;
         sync2_q <= sync1_q;
      end
   end

   assign cs_s  = sync2_q[0];
   assign cnv_s = sync2_q[1];
   assign fmt_s = sync2_q[2];
   assign pd_s  = sync2_q[3];
   assign fs_s  = sync2_q[4];

   /////////////////////////////////////////////////////////////////////////////
   // Conversion sequencer on the internal clock

   adcrd_pkg::adcrd_state_t st_q;
   adcrd_pkg::adcrd_state_t st_d;
   logic [CW-1:0]           cnt_q;
   logic [CW-1:0]           cnt_d;
   logic [W-1:0]            res_q;
   logic [W-1:0]            res_d;
   logic                    qual_q;
   logic                    qual_d;
   logic                    qual_prev_q;
   logic                    busy_q;
   logic                    busy_d;
   logic                    nap_q;
   logic                    nap_d;
   logic                    pdn_q;
   logic                    pdn_d;
   logic                    oe_q;
   logic                    oe_d;
   logic                    smp_q;
   logic                    smp_d;
   logic                    fs_mode_q;
   logic                    fs_mode_d;
   logic                    qual_fall;
   logic                    sample_go;

   // Edge of the qualified start as registered one cycle ago
   assign qual_fall = qual_prev_q & ~qual_q;
   assign sample_go = qual_q & ~cs_s;

   always_comb begin
      st_d      = st_q;
      cnt_d     = cnt_q;
      res_d     = res_q;
      busy_d    = busy_q;
      nap_d     = nap_q;
      pdn_d     = pdn_q;
      oe_d      = oe_q;
      smp_d     = smp_q;
      // Frame-sync framing is recognised once frame_sync has been seen low
      fs_mode_d = fs_mode_q | ~fs_s;
      qual_d    = cs_s ? qual_q : cnv_s;
      unique case (st_q)
         adcrd_pkg::ADCRD_WAIT: begin
            if (sample_go) begin
               st_d  = adcrd_pkg::ADCRD_SAMPLE;
               smp_d = 1'b1;
            end
         end
         adcrd_pkg::ADCRD_SAMPLE: begin
            if (qual_fall) begin
               st_d   = adcrd_pkg::ADCRD_CONV;
               cnt_d  = '0;
               busy_d = 1'b1;
               smp_d  = 1'b0;
            end
         end
         adcrd_pkg::ADCRD_CONV: begin
            if (qual_fall) begin
               st_d   = adcrd_pkg::ADCRD_WAIT;
               res_d  = `ADCRD_ABORT_CODE;
               busy_d = 1'b0;
            end else if (cnt_q == CONV_LAST) begin
               res_d  = fmt_code(core_code, fmt_s);
               busy_d = 1'b0;
               cnt_d  = '0;
               if (sample_go) begin
                  st_d  = adcrd_pkg::ADCRD_SAMPLE;
                  smp_d = 1'b1;
               end else if (!qual_q) begin
                  st_d = adcrd_pkg::ADCRD_NAP;
               end else begin
                  st_d = adcrd_pkg::ADCRD_WAIT;
               end
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         adcrd_pkg::ADCRD_NAP: begin
            // Low power state settles within the activation time
            if (cnt_q != NAP_LAST) begin
               cnt_d = cnt_q + 1'b1;
            end else begin
               nap_d = 1'b1;
            end
            if (sample_go) begin
               st_d  = adcrd_pkg::ADCRD_SAMPLE;
               smp_d = 1'b1;
               nap_d = 1'b0;
            end
         end
         adcrd_pkg::ADCRD_PDOWN: begin
            if (cnt_q != PD_LAST) begin
               cnt_d = cnt_q + 1'b1;
            end else begin
               pdn_d = 1'b1;
            end
            if (!pd_s) begin
               st_d  = adcrd_pkg::ADCRD_WAIT;
               cnt_d = '0;
               pdn_d = 1'b0;
               oe_d  = 1'b1;
            end
         end
      endcase
      // Power-down overrides everything and clears the result
      if (pd_s && st_q != adcrd_pkg::ADCRD_PDOWN) begin
         st_d   = adcrd_pkg::ADCRD_PDOWN;
         cnt_d  = '0;
         res_d  = `ADCRD_ZERO_CODE;
         busy_d = 1'b0;
         nap_d  = 1'b0;
         smp_d  = 1'b0;
         oe_d   = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q        <= adcrd_pkg::ADCRD_WAIT;
         cnt_q       <= '0;
         res_q       <= `ADCRD_ZERO_CODE;
         qual_q      <= 1'b1;
         qual_prev_q <= 1'b1;
         busy_q      <= 1'b0;
         nap_q       <= 1'b0;
         pdn_q       <= 1'b0;
         oe_q        <= 1'b1;
         smp_q       <= 1'b0;
         fs_mode_q   <= 1'b0;
      end else begin
         st_q        <= st_d;
         cnt_q       <= cnt_d;
         res_q       <= res_d;
         qual_q      <= qual_d;
         qual_prev_q <= qual_q;
         busy_q      <= busy_d;
         nap_q       <= nap_d;
         pdn_q       <= pdn_d;
         oe_q        <= oe_d;
         smp_q       <= smp_d;
         fs_mode_q   <= fs_mode_d;
      end
   end

   assign busy          = busy_q;
   assign nap_active    = nap_q;
   assign powered_down  = pdn_q;
   assign sample_active = smp_q;
   assign serial_out_oe = oe_q;

   /////////////////////////////////////////////////////////////////////////////
   // Shifter on the serial clock
   // Frame start is a pin-level clear, so the MSB shows with no clock edge.
   // The result word is read without a crossing: the host keeps frames away
   // from the busy fall, so the word is static while it is shifted.

   logic         link_rst_n;
   logic         armed_q;
   logic         armed_d;
   logic [W-1:0] sel_q;
   logic [W-1:0] sel_d;

   // Glitch-free pins are assumed; a runt pulse here restarts the frame
   assign link_rst_n = arst_n & ~chip_select_n
                     & ~(fs_mode_q & frame_sync);

   always_comb begin
      armed_d = 1'b1;
      sel_d   = armed_q ? {1'b0, sel_q[W-1:1]} : sel_q;
   end

   always_ff @(negedge serial_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         armed_q <= 1'b0;
      end else begin
         armed_q <= armed_d;
      end
   end

   always_ff @(posedge serial_clk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sel_q <= `ADCRD_MSB_SEL;
      end else begin
         sel_q <= sel_d;
      end
   end

   // Past the LSB the line reads low until the next frame
   assign serial_out_line = oe_q & (|(sel_q & res_q));

endmodule : adcrd_top

// File: shared/adcrd_cfg.svh
// Constants of the converter readout and power control block
`ifndef ADCRD_CFG_SVH
`define ADCRD_CFG_SVH
`define ADCRD_RES_W      18
`define ADCRD_CLK_NS     10
`define ADCRD_CONV_NS    1160
`define ADCRD_CONV_CYC   (`ADCRD_CONV_NS / `ADCRD_CLK_NS)
`define ADCRD_NAP_NS     200
`define ADCRD_NAP_CYC    (`ADCRD_NAP_NS / `ADCRD_CLK_NS)
`define ADCRD_PD_NS      10000
`define ADCRD_PD_CYC     (`ADCRD_PD_NS / `ADCRD_CLK_NS)
`define ADCRD_CNT_W      10
`define ADCRD_ABORT_CODE 18'h3fc00
`define ADCRD_MSB_SEL    18'h20000
`define ADCRD_ZERO_CODE  18'h00000
`define ADCRD_SYNC_W     5
// Idle pin levels {frame_sync, power_down_pin, format, convert_start_n, chip_select_n}
`define ADCRD_SYNC_IDLE  5'h13
`endif

// File: shared/adcrd_pkg.sv
// Types of the converter readout and power control block
package adcrd_pkg;
   typedef enum logic [4:0] {
      ADCRD_WAIT   = 5'h01,
      ADCRD_SAMPLE = 5'h02,
      ADCRD_CONV   = 5'h04,
      ADCRD_NAP    = 5'h08,
      ADCRD_PDOWN  = 5'h10
   } adcrd_state_t;
endpackage : adcrd_pkg

// File: tb/adcrd_chk.sv
// Checker: timing relations of the converter control at the block pins
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module adcrd_chk #(
   parameter int CONV_CYC = 116,
   parameter int NAP_CYC  = 20,
   parameter int PD_CYC   = 1000
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic arst_n,
   // Pins
   input wire logic chip_select_n,
   input wire logic power_down_pin,
   input wire logic serial_out_line,
   input wire logic serial_out_oe,
   // Status
   input wire logic sample_active,
   input wire logic busy,
   input wire logic nap_active,
   input wire logic powered_down
);
   // One spare cycle so an exact-length conversion never trips the bound
   localparam int CONV_MAX = CONV_CYC + 1;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   // Pins pass a two-stage synchroniser and a register, so four samples are needed; five leave one spare
   sequence s_pd_on;
      power_down_pin [*5];
   endsequence
   sequence s_pd_off;
      !power_down_pin [*5];
   endsequence
   chk_busy_bound: assert property ($rose(busy) |-> ##[1:CONV_MAX] !busy)
      else $error("busy held too long");
   chk_busy_hold: assert property ($rose(busy) |=> busy [*3])
      else $error("busy dropped early");
   chk_conv_start: assert property ($rose(busy) |-> $past(sample_active))
      else $error("conversion not started from sampling");
   chk_samp_excl: assert property (busy |-> !sample_active)
      else $error("sampling during conversion");
   chk_pd_float: assert property (s_pd_on |-> !serial_out_oe && !busy)
      else $error("output driven in power down");
   chk_pd_resume: assert property (s_pd_off |-> serial_out_oe)
      else $error("output not driven");
   chk_pd_quiet: assert property (powered_down |-> !busy && !sample_active && !nap_active)
      else $error("activity in power down");
   chk_nap_quiet: assert property (nap_active |-> !busy && !sample_active)
      else $error("activity in nap");
   chk_cs_gate: assert property (chip_select_n [*5] |-> !$rose(sample_active))
      else $error("sampling started while deselected");
   chk_dout_gate: assert property (!serial_out_oe |-> !serial_out_line)
      else $error("data line active while floated");
endmodule : adcrd_chk

// File: tb/adcrd_host.sv
// Host model: drives the serial link and reads result frames
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module adcrd_host (
   // Link to the converter
   output logic      serial_clk,
   output logic      chip_select_n,
   output logic      frame_sync,
   input  wire logic serial_out_line
);
   logic [17:0] word;
   event        got;
   initial begin
      serial_clk    = 1'b0;
      chip_select_n = 1'b1;
      frame_sync    = 1'b1;
      word          = '0;
   end
   task automatic hold(input logic cs, input logic fs);
      #4 chip_select_n = cs;
      frame_sync = fs;
   endtask : hold
   // The link clock stands still outside frames
   task automatic frame(input bit fsm, input int n);
      if (fsm) begin
         #4 frame_sync = 1'b1;
         #4 word = {17'h0, serial_out_line};
         frame_sync = 1'b0;
      end else begin
         #4 chip_select_n = 1'b1;
         #4 chip_select_n = 1'b0;
         #2 word = {17'h0, serial_out_line};
      end
      // A leading rise that must not shift
      #6 serial_clk = 1'b1;
      #2;
      for (int i = 1; i < n; i++) begin
         #4 serial_clk = 1'b0;
         #6 serial_clk = 1'b1;
         #2 word = {word[16:0], serial_out_line};
      end
      #4 serial_clk = 1'b0;
      ->got;
   endtask : frame
endmodule : adcrd_host

// File: tb/tb_top.sv
// Top bench: drives the converter block and scores its outputs
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module tb_top;
   localparam int CONV_CYC = 40;
   localparam int NAP_CYC  = 2;
   localparam int PD_CYC   = 4;
   logic        sys_clk, arst_n, serial_clk, chip_select_n, frame_sync;
   logic        serial_out_line, serial_out_oe, convert_start_n;
   logic        output_format_select, power_down_pin;
   logic        sample_active, busy, nap_active, powered_down;
   logic [17:0] core_code, c, e;
   logic [17:0] exp_q[$];
   logic [17:0] tbl[4] = '{18'h3ffff, 18'h20000, 18'h1ffff, 18'h00000};
   logic [31:0] rnd;
   int          fail_count, samples_checked;
   adcrd_top #(.CONV_CYC(CONV_CYC), .NAP_CYC(NAP_CYC), .PD_CYC(PD_CYC)) dut (.*);
   adcrd_host host (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
      .frame_sync(frame_sync), .serial_out_line(serial_out_line));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [17:0] fmt(input logic [17:0] v, input logic f);
      return f ? {~v[17], v[16:0]} : v;
   endfunction : fmt
   task automatic check(input logic [17:0] seen, input logic [17:0] want);
      samples_checked++;
      if (seen !== want) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask : check
   task automatic complete_run();
      if (fail_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   task automatic rd(input bit m, input int n, input logic [17:0] v);
      exp_q.push_back(v >> (18 - n));
      host.frame(m, n);
   endtask : rd
   task automatic conv(input logic [17:0] v, input logic f, input bit b2b);
      int k;
      cyc(1);
      core_code            = v;
      output_format_select = f;
      convert_start_n      = 1'b1;
      cyc(8);
      check({17'h0, sample_active}, 18'h1);
      convert_start_n = 1'b0;
      cyc(8);
      check({17'h0, busy}, 18'h1);
      if (b2b) convert_start_n = 1'b1;
      for (k = 0; busy === 1'b1 && k < 200; k++) cyc(1);
      if (k == 200) begin
         fail_count++;
         complete_run();
      end
      cyc(NAP_CYC + 6);
      check({16'h0, b2b ? sample_active : nap_active, serial_out_oe}, 18'h3);
   endtask : conv
   ////////////////////////////////////////////////////////////
   initial begin
      forever begin
         @(host.got);
         check(host.word, exp_q.pop_front());
      end
   end
   initial begin
      arst_n               = 1'b0;
      convert_start_n      = 1'b0;
      output_format_select = 1'b0;
      power_down_pin       = 1'b0;
      core_code            = '0;
      rnd                  = 32'h40f8;
      cyc(6);
      arst_n = 1'b1;
      cyc(3);
      convert_start_n = 1'b1;
      cyc(10);
      check({17'h0, sample_active}, 18'h0);
      host.hold(1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         c   = (i < 4) ? tbl[i] : rnd[17:0];
         e   = fmt(c, i[0]);
         conv(c, i[0], i == 5);
         rd(0, 18, e);
      end
      rd(0, 5, e);
      rd(0, 18, e);
      cyc(1);
      convert_start_n = 1'b1;
      cyc(8);
      convert_start_n = 1'b0;
      cyc(10);
      convert_start_n = 1'b1;
      cyc(6);
      convert_start_n = 1'b0;
      cyc(10);
      check({16'h0, busy, sample_active}, 18'h0);
      rd(0, 18, 18'h3fc00);
      cyc(1);
      power_down_pin = 1'b1;
      cyc(PD_CYC + 8);
      check({16'h0, serial_out_oe, powered_down}, 18'h1);
      power_down_pin = 1'b0;
      cyc(8);
      check({16'h0, serial_out_oe, powered_down}, 18'h2);
      host.hold(1'b0, 1'b0);
      conv(18'h20000, 1'b0, 1'b0);
      rd(1, 5, 18'h20000);
      rd(1, 18, 18'h20000);
      host.hold(1'b0, 1'b1);
      conv(18'h00000, 1'b0, 1'b0);
      check({17'h0, serial_out_line}, 18'h0);
      complete_run();
   end
endmodule : tb_top

bind adcrd_top adcrd_chk #(.CONV_CYC(CONV_CYC), .NAP_CYC(NAP_CYC), .PD_CYC(PD_CYC)) chk (.*);
